//--- hdl/iam_activity_monitor.sv
// Functional notes
// - flags set on input activity, held until read; a read clears its register
// - write to clock/frame register pulses the counter interval trigger
// - writes never alter the clock/frame activity flags
// - byte enables ignored; all enables off means no access, nothing cleared
// - bit 0 set by a rising edge of the system clock input
// - bit 1 set by a rising edge of the test-pattern data input
// - bit 2 set when rx fast frame pulse seen low then high
// - bit 3 set when tx fast frame pulse seen low then high
// - bits 4-7 set by rx frame pulse n low then high on clock n
// - bits 8-11 set by tx frame pulse n low then high on clock n
// - link register holds rx groups in 7:0, tx groups in 15:8
// - rx group set when its four lines seen low and high on line clocks
// - rx group also set via its four lines on hmvip clock g/2
// - rx group also set via its lowest line on the fast data clock
// - rx group 7 uses lines 28-31, hmvip clock 3, line 28
// - tx group set by all four line clocks; groups 0-3 also by hmvip clock g, group 7 also by fast clock
`default_nettype none
module iam_activity_monitor
  import iam_pkg::*;
(
  input wire logic clk, // 40 MHz register clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic [iam_pkg::ADDR_W-1:0] regAddr, // byte address
  input wire logic regRd, // read strobe, one cycle
  input wire logic regWr, // write strobe, one cycle
  input wire logic [iam_pkg::BE_W-1:0] regByteEnN, // byte enables, low active
  output logic [iam_pkg::DATA_W-1:0] regRdData_ff, // read data
  output logic regRdValid_ff, // read data valid pulse
  output logic performanceCountersTransfer_ff, // interval end pulse
  input wire logic systemClockInput, // monitored system clock
  input wire logic txPatternDataInput, // test-pattern data
  input wire logic rxFastFramepulseInput, // rx 8M frame pulse
  input wire logic rxFastFramepulseClock, // rx 8M frame pulse clock
  input wire logic txFastFramepulseInput, // tx 8M frame pulse
  input wire logic txFastFramepulseClock, // tx 8M frame pulse clock
  input wire logic [iam_pkg::NUM_FP-1:0] rxFramepulseInputs, // rx pulses
  input wire logic [iam_pkg::NUM_FP-1:0] rxHmvipClocks, // rx hmvip clocks
  input wire logic [iam_pkg::NUM_FP-1:0] txFramepulseInputs, // tx pulses
  input wire logic [iam_pkg::NUM_FP-1:0] txHmvipClocks, // tx hmvip clocks
  input wire logic [iam_pkg::NUM_LINES-1:0] rxData, // rx line data
  input wire logic [iam_pkg::NUM_LINES-1:0] rxLineClocks, // rx line clocks
  input wire logic rxFastDataClock, // rx 8M data clock
  input wire logic [iam_pkg::NUM_LINES-1:0] txLineClocks, // tx line clocks
  input wire logic txFastDataClock // tx 8M data clock
);
  import iam_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [NUM_GRP-1:0] groupAll(
    input logic [NUM_LINES-1:0] seen
  );
    logic [NUM_GRP-1:0] res;
    res = '0;
    for (int g = 0; g < NUM_GRP; g++) begin
      res[g] = &seen[g*GRP_LINES +: GRP_LINES];
    end
    return res;
  endfunction : groupAll

  // ==========================================================
  // state
  logic [CLK_FP_W-1:0] clkFpFlags_ff, nxt_clkFpFlags;
  logic [LINK_W-1:0] linkFlags_ff, nxt_linkFlags;
  logic prevSys_ff, prevPat_ff, prevRxFc_ff, prevTxFc_ff;
  logic prevRxFd_ff, prevTxFd_ff;
  logic [NUM_FP-1:0] prevRxHv_ff, prevTxHv_ff;
  logic [NUM_LINES-1:0] prevRxLc_ff, prevTxLc_ff;
  logic lowRxFast_ff, nxt_lowRxFast, lowTxFast_ff, nxt_lowTxFast;
  logic [NUM_FP-1:0] lowRxFp_ff, nxt_lowRxFp, lowTxFp_ff, nxt_lowTxFp;
  logic [NUM_LINES-1:0] lcLo_ff, nxt_lcLo, lcHi_ff, nxt_lcHi;
  logic [NUM_LINES-1:0] hvLo_ff, nxt_hvLo, hvHi_ff, nxt_hvHi;
  logic [NUM_GRP-1:0] fdLo_ff, nxt_fdLo, fdHi_ff, nxt_fdHi;
  logic [NUM_LINES-1:0] txSeen_ff, nxt_txSeen;
  logic [DATA_W-1:0] nxt_rdData;
  logic nxt_rdValid, nxt_xfer;
  logic access, rdClkFp, rdLink, wrClkFp;
  logic [CLK_FP_W-1:0] evtClkFp;
  logic [LINK_W-1:0] evtLink;
  logic [NUM_FP-1:0] rxHvFall, txHvFall, rxHvRise, txHvRise;
  logic rxFcFall, txFcFall, fdRise, lcRise, hvRise;
  logic [NUM_GRP-1:0] rxGrpLc, rxGrpHv, txGrpLc;

  always_comb begin
    access = (regRd | regWr) && (regByteEnN != BE_NONE_N);
    rdClkFp = access && regRd && (regAddr == OFF_CLK_FP_ACT);
    rdLink = access && regRd && (regAddr == OFF_LINK_ACT);
    wrClkFp = access && regWr && (regAddr == OFF_CLK_FP_ACT);
    rxHvFall = prevRxHv_ff & ~rxHmvipClocks;
    txHvFall = prevTxHv_ff & ~txHmvipClocks;
    rxHvRise = rxHmvipClocks & ~prevRxHv_ff;
    txHvRise = txHmvipClocks & ~prevTxHv_ff;
    rxFcFall = prevRxFc_ff & ~rxFastFramepulseClock;
    txFcFall = prevTxFc_ff & ~txFastFramepulseClock;
    fdRise = rxFastDataClock & ~prevRxFd_ff;
    evtClkFp = '0;
    evtClkFp[BIT_SYS_CLK] = systemClockInput & ~prevSys_ff;
    evtClkFp[BIT_TX_PAT] = txPatternDataInput & ~prevPat_ff;
    // rx fast pulse low then high
    evtClkFp[BIT_RX_FAST_FP] = rxFcFall & lowRxFast_ff & rxFastFramepulseInput;
    nxt_lowRxFast = (lowRxFast_ff & ~rdClkFp)
                  | (rxFcFall & ~rxFastFramepulseInput);
    // tx fast pulse low then high
    evtClkFp[BIT_TX_FAST_FP] = txFcFall & lowTxFast_ff & txFastFramepulseInput;
    nxt_lowTxFast = (lowTxFast_ff & ~rdClkFp)
                  | (txFcFall & ~txFastFramepulseInput);
    for (int n = 0; n < NUM_FP; n++) begin
      evtClkFp[BIT_RX_FP+n] = rxHvFall[n] & lowRxFp_ff[n]
                            & rxFramepulseInputs[n];
      nxt_lowRxFp[n] = (lowRxFp_ff[n] & ~rdClkFp)
                     | (rxHvFall[n] & ~rxFramepulseInputs[n]);
      evtClkFp[BIT_TX_FP+n] = txHvFall[n] & lowTxFp_ff[n]
                            & txFramepulseInputs[n];
      nxt_lowTxFp[n] = (lowTxFp_ff[n] & ~rdClkFp)
                     | (txHvFall[n] & ~txFramepulseInputs[n]);
    end
    // seen state restarts on a read so a new interval needs new evidence
    for (int i = 0; i < NUM_LINES; i++) begin
      lcRise = rxLineClocks[i] & ~prevRxLc_ff[i];
      nxt_lcLo[i] = (lcLo_ff[i] & ~rdLink) | (lcRise & ~rxData[i]);
      nxt_lcHi[i] = (lcHi_ff[i] & ~rdLink) | (lcRise & rxData[i]);
      // shared hmvip clock, one per two groups
      hvRise = rxHvRise[i / LINES_PER_HV];
      nxt_hvLo[i] = (hvLo_ff[i] & ~rdLink) | (hvRise & ~rxData[i]);
      nxt_hvHi[i] = (hvHi_ff[i] & ~rdLink) | (hvRise & rxData[i]);
      nxt_txSeen[i] = (txSeen_ff[i] & ~rdLink)
                    | (txLineClocks[i] & ~prevTxLc_ff[i]);
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      // lowest line on fast data clock
      nxt_fdLo[g] = (fdLo_ff[g] & ~rdLink) | (fdRise & ~rxData[g*GRP_LINES]);
      nxt_fdHi[g] = (fdHi_ff[g] & ~rdLink) | (fdRise & rxData[g*GRP_LINES]);
    end
    // next-state seen bits, so stale evidence cannot re-set a cleared flag
    rxGrpLc = groupAll(nxt_lcLo & nxt_lcHi);
    rxGrpHv = groupAll(nxt_hvLo & nxt_hvHi);
    txGrpLc = groupAll(nxt_txSeen);
    evtLink = '0;
    for (int g = 0; g < NUM_GRP; g++) begin
      evtLink[BIT_RX_GRP+g] = rxGrpLc[g] | rxGrpHv[g]
                            | (nxt_fdLo[g] & nxt_fdHi[g]);
      evtLink[BIT_TX_GRP+g] = txGrpLc[g];
    end
    for (int g = 0; g < TX_HV_GRPS; g++) begin
      evtLink[BIT_TX_GRP+g] = evtLink[BIT_TX_GRP+g] | txHvRise[g];
    end
    evtLink[BIT_TX_GRP+TX_FAST_GRP] = evtLink[BIT_TX_GRP+TX_FAST_GRP]
                                    | (txFastDataClock & ~prevTxFd_ff);
    nxt_clkFpFlags = (clkFpFlags_ff & ~{CLK_FP_W{rdClkFp}}) | evtClkFp;
    nxt_linkFlags = (linkFlags_ff & ~{LINK_W{rdLink}}) | evtLink;
    nxt_rdData = '0;
    if (rdClkFp) begin
      nxt_rdData = {{(DATA_W-CLK_FP_W){1'b0}}, clkFpFlags_ff};
    end else if (rdLink) begin
      nxt_rdData = {{(DATA_W-LINK_W){1'b0}}, linkFlags_ff};
    end
    nxt_rdValid = regRd;
    nxt_xfer = wrClkFp;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkFpFlags_ff <= CLK_FP_RST;
      linkFlags_ff <= LINK_RST;
      {prevSys_ff, prevPat_ff, prevRxFc_ff, prevTxFc_ff} <= 4'h0;
      {prevRxFd_ff, prevTxFd_ff, lowRxFast_ff, lowTxFast_ff} <= 4'h0;
      {prevRxHv_ff, prevTxHv_ff, lowRxFp_ff, lowTxFp_ff} <= 16'h0000;
      {prevRxLc_ff, prevTxLc_ff, txSeen_ff} <= '0;
      {lcLo_ff, lcHi_ff, hvLo_ff, hvHi_ff, fdLo_ff, fdHi_ff} <= '0;
      regRdData_ff <= '0;
      regRdValid_ff <= 1'b0;
      performanceCountersTransfer_ff <= 1'b0;
    end else begin
      clkFpFlags_ff <= nxt_clkFpFlags;
      linkFlags_ff <= nxt_linkFlags;
      prevSys_ff <= systemClockInput;
      prevPat_ff <= txPatternDataInput;
      prevRxFc_ff <= rxFastFramepulseClock;
      prevTxFc_ff <= txFastFramepulseClock;
      prevRxFd_ff <= rxFastDataClock;
      prevTxFd_ff <= txFastDataClock;
      prevRxHv_ff <= rxHmvipClocks;
      prevTxHv_ff <= txHmvipClocks;
      prevRxLc_ff <= rxLineClocks;
      prevTxLc_ff <= txLineClocks;
      lowRxFast_ff <= nxt_lowRxFast;
      lowTxFast_ff <= nxt_lowTxFast;
      lowRxFp_ff <= nxt_lowRxFp;
      lowTxFp_ff <= nxt_lowTxFp;
      lcLo_ff <= nxt_lcLo;
      lcHi_ff <= nxt_lcHi;
      hvLo_ff <= nxt_hvLo;
      hvHi_ff <= nxt_hvHi;
      fdLo_ff <= nxt_fdLo;
      fdHi_ff <= nxt_fdHi;
      txSeen_ff <= nxt_txSeen;
      regRdData_ff <= nxt_rdData;
      regRdValid_ff <= nxt_rdValid;
      performanceCountersTransfer_ff <= nxt_xfer;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rd_clears;
    rdClkFp |=> clkFpFlags_ff == $past(evtClkFp);
  endproperty
  a_rd_clears: assert property (p_rd_clears)
    else $error("clock register read did not clear flags");

  property p_xfer;
    wrClkFp |=> performanceCountersTransfer_ff ##1
      !performanceCountersTransfer_ff || $past(wrClkFp);
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("interval trigger wrong after write");

  property p_wr_keeps;
    (wrClkFp && !regRd) |=>
      clkFpFlags_ff == ($past(clkFpFlags_ff) | $past(evtClkFp));
  endproperty
  a_wr_keeps: assert property (p_wr_keeps)
    else $error("write altered activity flags");

  property p_no_be;
    (regRd && regByteEnN == BE_NONE_N) |=>
      linkFlags_ff == ($past(linkFlags_ff) | $past(evtLink))
      && regRdData_ff == '0;
  endproperty
  a_no_be: assert property (p_no_be)
    else $error("access without byte enables had an effect");

  property p_sys_rise;
    (systemClockInput && !prevSys_ff) |=> clkFpFlags_ff[BIT_SYS_CLK];
  endproperty
  a_sys_rise: assert property (p_sys_rise)
    else $error("system clock edge not flagged");

  property p_pat_rise;
    $rose(txPatternDataInput) |-> ##1 clkFpFlags_ff[BIT_TX_PAT];
  endproperty
  a_pat_rise: assert property (p_pat_rise)
    else $error("pattern data edge not flagged");

  property p_rx_fast;
    (lowRxFast_ff && rxFcFall && rxFastFramepulseInput)
      |=> clkFpFlags_ff[BIT_RX_FAST_FP];
  endproperty
  a_rx_fast: assert property (p_rx_fast)
    else $error("rx fast frame pulse not flagged");

  property p_link_layout;
    rdLink |=> regRdValid_ff && regRdData_ff[DATA_W-1:LINK_W] == '0
      && regRdData_ff[LINK_W-1:0] == $past(linkFlags_ff);
  endproperty
  a_link_layout: assert property (p_link_layout)
    else $error("link register read data wrong");

  property p_tx_hv;
    txHvRise[0] |=> linkFlags_ff[BIT_TX_GRP];
  endproperty
  a_tx_hv: assert property (p_tx_hv)
    else $error("tx hmvip clock edge not flagged");
  property p_survive;
    (rdClkFp && evtClkFp[BIT_SYS_CLK]) |=> clkFpFlags_ff[BIT_SYS_CLK];
  endproperty
  a_survive: assert property (p_survive)
    else $error("event lost during clearing read");
  property p_cv_read_set;
    rdClkFp && clkFpFlags_ff[BIT_SYS_CLK];
  endproperty
  c_cv_read_set: cover property (p_cv_read_set);
  property p_cv_rx_grp;
    rdLink && linkFlags_ff[BIT_RX_GRP];
  endproperty
  c_cv_rx_grp: cover property (p_cv_rx_grp);
  property p_cv_xfer;
    performanceCountersTransfer_ff;
  endproperty
  c_cv_xfer: cover property (p_cv_xfer);
endmodule : iam_activity_monitor
`default_nettype wire

//--- shared/iam_pkg.sv
`default_nettype none
package iam_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CLK_FP_ACT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_LINK_ACT = 12'h010;
  localparam logic [BE_W-1:0] BE_NONE_N = 4'hF;
  // ==========================================================
  // field layout of the clock / frame pulse register
  localparam int CLK_FP_W = 12;
  localparam int BIT_SYS_CLK = 0;
  localparam int BIT_TX_PAT = 1;
  localparam int BIT_RX_FAST_FP = 2;
  localparam int BIT_TX_FAST_FP = 3;
  localparam int BIT_RX_FP = 4;
  localparam int BIT_TX_FP = 8;
  localparam int NUM_FP = 4;
  // ==========================================================
  // field layout of the link register
  localparam int LINK_W = 16;
  localparam int BIT_RX_GRP = 0;
  localparam int BIT_TX_GRP = 8;
  localparam int NUM_GRP = 8;
  localparam int GRP_LINES = 4;
  localparam int NUM_LINES = 32;
  localparam int LINES_PER_HV = 8;
  localparam int TX_HV_GRPS = 4;
  localparam int TX_FAST_GRP = 7;
  localparam logic [CLK_FP_W-1:0] CLK_FP_RST = 12'h000;
  localparam logic [LINK_W-1:0] LINK_RST = 16'h0000;
endpackage : iam_pkg
`default_nettype wire

//--- dv/iam_host_model.sv
`default_nettype none
module iam_host_model
  import iam_pkg::*;
(
  input wire logic clk, // register clock
  output logic [iam_pkg::ADDR_W-1:0] regAddr, // byte address
  output logic regRd, // read strobe
  output logic regWr, // write strobe
  output logic [iam_pkg::BE_W-1:0] regByteEnN, // enables, low active
  input wire logic [iam_pkg::DATA_W-1:0] regRdData_ff, // read data
  input wire logic regRdValid_ff // read data valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // host access tasks
  initial begin
    regAddr = '0;
    regRd = 1'b0;
    regWr = 1'b0;
    regByteEnN = 4'hF;
  end
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be,
      output logic v, output logic [DATA_W-1:0] d);
    @(negedge clk);
    regAddr = a;
    regByteEnN = be;
    regRd = 1'b1;
    @(negedge clk);
    // answer stands one cycle only: take it before releasing
    v = regRdValid_ff;
    d = regRdData_ff;
    regRd = 1'b0;
    // released bus shows junk, not the last value
    regAddr = ~a;
    regByteEnN = ~be;
  endtask : rd
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be);
    @(negedge clk);
    regAddr = a;
    regByteEnN = be;
    regWr = 1'b1;
    @(negedge clk);
    regWr = 1'b0;
    regAddr = ~a;
    regByteEnN = ~be;
  endtask : wr
endmodule : iam_host_model
`default_nettype wire

//--- dv/iam_activity_monitor_test.sv
`default_nettype none
module iam_activity_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import iam_pkg::*;
  logic clk, sys_rst, regRd, regWr, regRdValid_ff, xferPulse;
  logic [ADDR_W-1:0] regAddr;
  logic [BE_W-1:0] regByteEnN;
  logic [DATA_W-1:0] regRdData_ff;
  logic sysClkIn, patIn, rxFastClk, txFastClk;
  logic [9:0] fpClk, fpIn;
  logic [31:0] rxData, rxLineClocks, txLineClocks;
  int errors, comparisons;
  // ==========================================================
  // block and host
  iam_activity_monitor iam_activity_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regRd(regRd),
    .regWr(regWr), .regByteEnN(regByteEnN), .regRdData_ff(regRdData_ff),
    .regRdValid_ff(regRdValid_ff),
    .performanceCountersTransfer_ff(xferPulse),
    .systemClockInput(sysClkIn), .txPatternDataInput(patIn),
    .rxFastFramepulseInput(fpIn[0]), .rxFastFramepulseClock(fpClk[0]),
    .txFastFramepulseInput(fpIn[1]), .txFastFramepulseClock(fpClk[1]),
    .rxFramepulseInputs(fpIn[5:2]), .rxHmvipClocks(fpClk[5:2]),
    .txFramepulseInputs(fpIn[9:6]), .txHmvipClocks(fpClk[9:6]),
    .rxData(rxData), .rxLineClocks(rxLineClocks),
    .rxFastDataClock(rxFastClk), .txLineClocks(txLineClocks),
    .txFastDataClock(txFastClk));
  iam_host_model iam_host_model_inst (
    .clk(clk), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
    .regByteEnN(regByteEnN), .regRdData_ff(regRdData_ff),
    .regRdValid_ff(regRdValid_ff));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic chk_word(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic rd_chk(input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] exp);
    logic v;
    logic [31:0] d;
    iam_host_model_inst.rd(a, be, v, d);
    chk_bit("read valid", 1'b1, v);
    chk_word("read data", exp, d);
  endtask : rd_chk
  // pulse must land exactly one cycle after the write
  task automatic wr_chk(input logic [11:0] a, input logic [3:0] be,
      input logic exp);
    chk_bit("transfer early", 1'b0, xferPulse);
    iam_host_model_inst.wr(a, be);
    chk_bit("transfer", exp, xferPulse);
    tick(1);
    chk_bit("transfer end", 1'b0, xferPulse);
  endtask : wr_chk
  task automatic set_rx_clk(input int sel, input logic v);
    case (sel)
      0: rxLineClocks = {32{v}};
      1: fpClk[5:2] = {4{v}};
      default: rxFastClk = v;
    endcase
  endtask : set_rx_clk
  // two rising edges: first sees all lines low, second sees hi
  task automatic rx_two(input int sel, input logic [31:0] hi);
    rxData = '0;
    repeat (2) begin
      set_rx_clk(sel, 1'b1);
      tick(1);
      set_rx_clk(sel, 1'b0);
      rxData = hi;
      tick(1);
    end
    tick(1);
  endtask : rx_two
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // scenarios
  task automatic t_basic;
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h0);
    rd_chk(OFF_LINK_ACT, 4'h0, 32'h0);
    sysClkIn = 1'b1;
    patIn = 1'b1;
    tick(1);
    sysClkIn = 1'b0;
    patIn = 1'b0;
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h3);
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h0);
    $display("test basic done");
  endtask : t_basic
  task automatic t_write;
    sysClkIn = 1'b1;
    tick(1);
    sysClkIn = 1'b0;
    wr_chk(OFF_CLK_FP_ACT, 4'h0, 1'b1);
    wr_chk(OFF_LINK_ACT, 4'h0, 1'b0);
    wr_chk(OFF_CLK_FP_ACT, 4'hF, 1'b0);
    rd_chk(OFF_CLK_FP_ACT, 4'hF, 32'h0);
    rd_chk(12'h014, 4'h0, 32'h0);
    rd_chk(OFF_CLK_FP_ACT, 4'h5, 32'h1);
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h0);
    $display("test write done");
  endtask : t_write
  task automatic t_fp;
    fpClk = '1;
    tick(1);
    fpClk = '0;
    tick(1);
    fpIn = '1;
    fpClk = '1;
    tick(1);
    // pulse must still be high at the falling edge that flags it
    fpClk = '0;
    tick(1);
    fpIn = '0;
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'hFFC);
    rd_chk(OFF_LINK_ACT, 4'h0, 32'h0F00);
    $display("test frame pulse done");
  endtask : t_fp
  task automatic t_links;
    rx_two(0, 32'hFFFFDFFF);
    rd_chk(OFF_LINK_ACT, 4'h0, 32'h00F7);
    rx_two(1, 32'hF000FFFF);
    rd_chk(OFF_LINK_ACT, 4'h0, 32'h008F);
    rx_two(2, 32'h10000001);
    rd_chk(OFF_LINK_ACT, 4'h0, 32'h0081);
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h0);
    txLineClocks = 32'h0FFF0007;
    txFastClk = 1'b1;
    tick(1);
    txLineClocks = '0;
    txFastClk = 1'b0;
    rd_chk(OFF_LINK_ACT, 4'h0, 32'hF000);
    rd_chk(OFF_LINK_ACT, 4'h0, 32'h0);
    $display("test links done");
  endtask : t_links
  // edge taken in the very cycle of the clearing read
  task automatic t_race;
    fork
      rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h0);
      begin
        tick(1);
        sysClkIn = 1'b1;
        tick(1);
        sysClkIn = 1'b0;
      end
    join
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h1);
    $display("test read race done");
  endtask : t_race
  // flags taken before a mid-run reset must not survive it
  task automatic t_reset;
    sysClkIn = 1'b1;
    tick(1);
    sysClkIn = 1'b0;
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    rd_chk(OFF_CLK_FP_ACT, 4'h0, 32'h0);
    rd_chk(OFF_LINK_ACT, 4'h0, 32'h0);
    $display("test reset done");
  endtask : t_reset
  initial begin
    {sys_rst, sysClkIn, patIn, rxFastClk, txFastClk} = 5'b10000;
    {fpClk, fpIn} = '0;
    {rxData, rxLineClocks, txLineClocks} = '0;
    tick(4);
    sys_rst = 1'b0;
    t_basic();
    t_write();
    t_fp();
    t_links();
    t_race();
    t_reset();
    complete_run();
  end
  // whole run is near 80 cycles; 25 times that means a hang
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : iam_activity_monitor_test
`default_nettype wire
